// ===== ssia_status_image_alarms.sv
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// - Byte 0 of both images: run, standby, dirt warn/fault, contour, tamper; bits 7:6 zero.
// - Bytes 1-3: safe, nonsafe, rearm-needed path bits; bit n-1 is path n.
// - Byte 4 of each image is the active monitoring case number.
// - Alarm 64 on destination address mismatch, 65 on invalid destination address.
// - Alarm 66 when the source address is invalid or incorrect.
// - Alarm 67 when watchdog time parameter is zero.
// - Alarm 68 when requested integrity level exceeds device level.
// - Alarm 69 when configured CRC length disagrees with received CRC length.
// - Alarm 70 when parameter version is unsupported.
// - Alarm 71 when parameter block consistency CRC fails.
// - Alarm 72 for device-specific or unclassified diagnostics.
// - Alarm 75 when individual parameter checksum mismatches configured value.
// - Alarm 77 when a telegram fails its data CRC.
// - Alarm 78 when a safety watchdog expires in run mode; outside run mode the expiry reports 263.
// - Alarms 64-78 are Error; 256 and above need maintenance.
// - Alarm 256 on application usage error.
// - Alarm 257 on internal device fault.
// - Alarm 258 on dirt warning; 259 on dirt fault, safety outputs off.
// - Alarm 260 and outputs off when reference contour missing.
// - Alarm 261 and outputs off when no contour over 90 degrees.
module ssia_status_image_alarms #(
    parameter int PATHS = ssia_pkg::PATH_COUNT,
    parameter logic [15:0] OWN_ADDR = 16'h0001, // arbitrary
    parameter logic [1:0] DEVICE_SIL = 2'h3,
    parameter bit EXTENDED = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Measurement side, same clock
    input wire logic [PATHS-1:0] pathSafeIn,
    input wire logic [PATHS-1:0] pathNonsafeIn,
    input wire logic [PATHS-1:0] pathRearmIn,
    input wire logic contourLostIn,
    input wire logic angleBlindIn,
    input wire logic crc1BadIn,
    input wire logic crc2BadIn,
    input wire logic iparCrcBadIn,
    input wire logic watchdogExpiredIn,
    input wire logic [1:0] rxCrcLen4In,
    // Images and alarm
    output logic [47:0] safeImage,
    output logic [47:0] plainImage,
    output ssia_pkg::ssia_alarm_type alarm,
    output logic safeOutputsOff
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    logic [31:0] modeCtrl_q;
    logic [31:0] pathCtrl_q;
    logic [31:0] faultCtrl_q;
    logic [31:0] fparam_q;
    logic [31:0] fparamHi_q;
    logic [31:0] readdata_q;
    logic ack_q;
    logic [ssia_pkg::NUM_ALARMS-1:0] pend_q;

    wire access = (read | write) & ~ack_q;
    assign waitrequest = (read | write) & ~ack_q;

    wire wrMode = write & ack_q & (address == ssia_pkg::ADDR_MODE_CTRL);
    wire wrPath = write & ack_q & (address == ssia_pkg::ADDR_PATH_CTRL);
    wire wrFault = write & ack_q & (address == ssia_pkg::ADDR_FAULT_IN);
    wire wrAck = write & ack_q & (address == ssia_pkg::ADDR_ALARM_ACK);
    wire wrParam = write & ack_q & (address == ssia_pkg::ADDR_FPARAM);
    wire wrParamHi = write & ack_q & (address == ssia_pkg::ADDR_SAFE_OUT);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Device state assembled from software and measurement inputs
    ssia_pkg::ssia_state_type st;
    ssia_pkg::ssia_fparam_type fp;
    assign st.runMode = modeCtrl_q[ssia_pkg::BIT_RUN];
    assign st.standby = modeCtrl_q[ssia_pkg::BIT_STANDBY];
    assign st.dirtWarning = modeCtrl_q[ssia_pkg::BIT_DIRT_WARN];
    assign st.dirtFault = modeCtrl_q[ssia_pkg::BIT_DIRT_FAULT];
    assign st.referenceContour = contourLostIn;
    assign st.tamper = angleBlindIn;
    assign st.internalFault = faultCtrl_q[1];
    assign st.usageFault = faultCtrl_q[0];
    assign st.caseNumber = modeCtrl_q[15:8];
    // Low word holds watchdog, level, CRC length, version and block id: 23 bits
    assign fp = {fparamHi_q, fparam_q[22:0]};

    // Paths 5..8 only with the extended package
    localparam int LIVE = EXTENDED ? PATHS : ssia_pkg::BASIC_PATHS;
    logic [7:0] safeBits;
    logic [7:0] nonsafeBits;
    logic [7:0] rearmBits;
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gPath
            if (g < LIVE && g < PATHS) begin : gLive
                assign safeBits[g] = pathSafeIn[g] & pathCtrl_q[g] & ~safeOutputsOff;
                assign nonsafeBits[g] = pathNonsafeIn[g];
                assign rearmBits[g] = pathRearmIn[g];
            end else begin : gAbsent
                assign safeBits[g] = 1'b0;
                assign nonsafeBits[g] = 1'b0;
                assign rearmBits[g] = 1'b0;
            end
        end
    endgenerate

    // Dirt fault, contour loss and tamper override every safety output
    wire forceOff = st.dirtFault | st.referenceContour | st.tamper;

    wire [7:0] byte0 = {2'b00, st.tamper, st.referenceContour, st.dirtFault, st.dirtWarning,
                        st.standby, st.runMode};
    logic [7:0] safeByte5;
    logic [7:0] plainByte5;
    always_comb begin
        safeByte5 = 8'h00;
        safeByte5[ssia_pkg::SAFE_BIT_USAGE] = st.usageFault;
        safeByte5[ssia_pkg::SAFE_BIT_INTERNAL] = st.internalFault;
        plainByte5 = 8'h00;
        plainByte5[ssia_pkg::PLAIN_BIT_USAGE] = st.usageFault;
        plainByte5[ssia_pkg::PLAIN_BIT_INTERNAL] = st.internalFault;
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm conditions, index order matches the number table
    logic [ssia_pkg::NUM_ALARMS-1:0] cond;
    logic extraCond;
    always_comb begin
        cond = '0;
        cond[0] = (fp.destAddr != OWN_ADDR) && (fp.destAddr != 16'h0000) && (fp.destAddr != 16'hffff);
        cond[1] = (fp.destAddr == 16'h0000) || (fp.destAddr == 16'hffff);
        cond[2] = (fp.srcAddr == 16'h0000) || (fp.srcAddr == OWN_ADDR);
        cond[3] = fp.wdTime == 16'h0000;
        cond[4] = fp.sil > DEVICE_SIL;
        cond[5] = (fp.crcLen4 ? 2'h1 : 2'h0) != rxCrcLen4In;
        cond[6] = fp.paramVersion != ssia_pkg::SUPPORTED_VERSION;
        cond[7] = crc1BadIn;
        cond[8] = faultCtrl_q[2];
        cond[9] = iparCrcBadIn;
        cond[10] = fp.blockId > ssia_pkg::MAX_BLOCK_ID;
        cond[11] = crc2BadIn;
        // Outside run mode an expiry means inactive comms, reported as 263
        cond[12] = watchdogExpiredIn & st.runMode;
        cond[13] = st.usageFault;
        cond[14] = st.internalFault;
        cond[15] = st.dirtWarning;
        cond[16] = st.dirtFault;
        cond[17] = st.referenceContour;
        cond[18] = st.tamper;
        cond[19] = faultCtrl_q[3];
        extraCond = watchdogExpiredIn & ~st.runMode;
    end

    // Lowest pending index reported first
    logic [4:0] sel;
    logic any;
    always_comb begin
        sel = '0;
        any = 1'b0;
        for (int i = ssia_pkg::NUM_ALARMS - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                sel = 5'(i);
                any = 1'b1;
            end
        end
    end

    ssia_pkg::ssia_alarm_type alarm_d;
    always_comb begin
        alarm_d = '0;
        if (any) begin
            alarm_d.valid = 1'b1;
            alarm_d.number = ssia_pkg::ALARM_NUMBER[sel];
        end else if (extraCond) begin
            alarm_d.valid = 1'b1;
            alarm_d.number = ssia_pkg::ALARM_NUM_EXTRA;
        end
        if (alarm_d.valid) begin
            alarm_d.severity = (alarm_d.number >= ssia_pkg::MAINT_FIRST) ?
                ssia_pkg::SEV_MAINT : ssia_pkg::SEV_ERROR;
        end
    end

    // Set wins over acknowledge clear
    wire [ssia_pkg::NUM_ALARMS-1:0] ackMask = wrAck ? writedata[ssia_pkg::NUM_ALARMS-1:0] : '0;
    wire [ssia_pkg::NUM_ALARMS-1:0] pend_d = (pend_q & ~ackMask) | cond;

    logic [31:0] rd;
    always_comb begin
        case (address)
            ssia_pkg::ADDR_MODE_CTRL: rd = modeCtrl_q;
            ssia_pkg::ADDR_PATH_CTRL: rd = pathCtrl_q;
            ssia_pkg::ADDR_FAULT_IN: rd = faultCtrl_q;
            ssia_pkg::ADDR_SAFE_IMG: rd = {safeImage[31:0]};
            ssia_pkg::ADDR_PLAIN_IMG: rd = {plainImage[31:0]};
            ssia_pkg::ADDR_ALARM: rd = {20'h00000, alarm};
            ssia_pkg::ADDR_ALARM_ACK: rd = {12'h000, pend_q};
            ssia_pkg::ADDR_SAFE_OUT: rd = fparamHi_q;
            ssia_pkg::ADDR_FPARAM: rd = fparam_q;
            default: rd = ssia_pkg::UNMAPPED_READ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            readdata_q <= 32'h00000000;
        end else begin
            ack_q <= access;
            readdata_q <= rd;
        end
    end
    assign readdata = readdata_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modeCtrl_q <= 32'h00000000;
            pathCtrl_q <= 32'h00000000;
            faultCtrl_q <= 32'h00000000;
        end else begin
            if (wrMode) modeCtrl_q <= merge(modeCtrl_q, writedata, byteenable);
            if (wrPath) pathCtrl_q <= merge(pathCtrl_q, writedata, byteenable);
            if (wrFault) faultCtrl_q <= merge(faultCtrl_q, writedata, byteenable);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fparam_q <= 32'h00000000;
            fparamHi_q <= 32'h00000000;
        end else begin
            if (wrParam) fparam_q <= merge(fparam_q, writedata, byteenable);
            if (wrParamHi) fparamHi_q <= merge(fparamHi_q, writedata, byteenable);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_q <= '0;
            alarm <= '0;
            safeOutputsOff <= 1'b1;
            safeImage <= 48'h000000000000;
            plainImage <= 48'h000000000000;
        end else begin
            pend_q <= pend_d;
            alarm <= alarm_d;
            safeOutputsOff <= forceOff;
            safeImage <= {safeByte5, st.caseNumber, rearmBits, nonsafeBits, safeBits, byte0};
            plainImage <= {plainByte5, st.caseNumber, rearmBits, nonsafeBits, safeBits, byte0};
        end
    end

endmodule

// ===== ssia_pkg.sv
package ssia_pkg;

    // Avalon-MM register map (word aligned byte addresses)
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PATH_CTRL = 8'h04;
    localparam logic [7:0] ADDR_FAULT_IN = 8'h08;
    localparam logic [7:0] ADDR_SAFE_IMG = 8'h0c;
    localparam logic [7:0] ADDR_PLAIN_IMG = 8'h10;
    localparam logic [7:0] ADDR_ALARM = 8'h14;
    localparam logic [7:0] ADDR_ALARM_ACK = 8'h18;
    localparam logic [7:0] ADDR_SAFE_OUT = 8'h1c;
    localparam logic [7:0] ADDR_FPARAM = 8'h20;
    localparam logic [31:0] UNMAPPED_READ = 32'hdeadbeef;

    // Status byte 0 layout
    localparam int BIT_RUN = 0;
    localparam int BIT_STANDBY = 1;
    localparam int BIT_DIRT_WARN = 2;
    localparam int BIT_DIRT_FAULT = 3;
    localparam int BIT_REF_CONTOUR = 4;
    localparam int BIT_TAMPER = 5;

    // Status byte 5 layout, safety image and plain image differ
    localparam int SAFE_BIT_USAGE = 4;
    localparam int SAFE_BIT_INTERNAL = 5;
    localparam int PLAIN_BIT_USAGE = 3;
    localparam int PLAIN_BIT_INTERNAL = 4;

    localparam int PATH_COUNT = 8;
    localparam int BASIC_PATHS = 4;
    localparam int IMG_BYTES = 6;

    // Alarm numbers
    localparam int NUM_ALARMS = 20;
    localparam logic [8:0] ALARM_NUMBER [NUM_ALARMS] = '{
        9'h040, 9'h041, 9'h042, 9'h043, 9'h044, 9'h045, 9'h046, 9'h047,
        9'h048, 9'h04b, 9'h04c, 9'h04d, 9'h04e,
        9'h100, 9'h101, 9'h102, 9'h103, 9'h104, 9'h105, 9'h106};
    localparam logic [8:0] ALARM_NUM_EXTRA = 9'h107;
    localparam logic [8:0] MAINT_FIRST = 9'h100;

    typedef enum logic [1:0] {SEV_NONE, SEV_ERROR, SEV_MAINT} ssia_sev_type;

    typedef struct packed {
        logic [8:0] number;
        ssia_sev_type severity;
        logic valid;
    } ssia_alarm_type;

    typedef struct packed {
        logic runMode;
        logic standby;
        logic dirtWarning;
        logic dirtFault;
        logic referenceContour;
        logic tamper;
        logic internalFault;
        logic usageFault;
        logic [7:0] caseNumber;
    } ssia_state_type;

    // Configured safety parameters, checked against device view
    typedef struct packed {
        logic [15:0] destAddr;
        logic [15:0] srcAddr;
        logic [15:0] wdTime;
        logic [1:0] sil;
        logic crcLen4;
        logic [1:0] paramVersion;
        logic [1:0] blockId;
    } ssia_fparam_type;

    localparam logic [1:0] SUPPORTED_VERSION = 2'h0;
    localparam logic [1:0] MAX_BLOCK_ID = 2'h1;

endpackage

// ===== ssia_status_image_alarms_asserts.sv
`timescale 1ns/10ps
module ssia_status_image_alarms_asserts #(
    parameter int PATHS = ssia_pkg::PATH_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    // Measurement
    input wire logic [PATHS-1:0] pathNonsafeIn,
    input wire logic [PATHS-1:0] pathRearmIn,
    input wire logic contourLostIn,
    input wire logic angleBlindIn,
    // Images and alarm
    input wire logic [47:0] safeImage,
    input wire logic [47:0] plainImage,
    input wire ssia_pkg::ssia_alarm_type alarm,
    input wire logic safeOutputsOff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    sequence s_req_wait;
        (read || write) && waitrequest;
    endsequence
    // Images lag the inputs by one edge, so skip the edge after reset
    sequence s_live;
        !$past(sys_rst);
    endsequence
    a_wait_one: assert property (s_req_wait |=> !waitrequest) else $error("wait state too long");
    a_resv_zero: assert property (safeImage[7:6] == 2'h0 && plainImage[7:6] == 2'h0)
        else $error("byte 0 reserved bits set");
    a_flags_same: assert property (safeImage[5:0] == plainImage[5:0]) else $error("byte 0 differs");
    a_byte5_resv: assert property (safeImage[47:46] == 2'h0 && safeImage[43:40] == 4'h0
        && plainImage[47:45] == 3'h0 && plainImage[42:40] == 3'h0) else $error("byte 5 reserved set");
    a_nonsafe_path: assert property (s_live |-> safeImage[23:16] == 8'($past(pathNonsafeIn))
        && plainImage[23:16] == 8'($past(pathNonsafeIn))) else $error("nonsafe path byte wrong");
    a_rearm_path: assert property (s_live |-> safeImage[31:24] == 8'($past(pathRearmIn))
        && plainImage[31:24] == 8'($past(pathRearmIn))) else $error("rearm path byte wrong");
    a_case_same: assert property (safeImage[39:32] == plainImage[39:32]) else $error("case differs");
    a_contour_off: assert property (s_live ##0 $past(contourLostIn) |-> safeOutputsOff)
        else $error("outputs on with contour lost");
    a_blind_off: assert property (s_live ##0 $past(angleBlindIn) |-> safeOutputsOff)
        else $error("outputs on with blind angle");
    a_sev_error: assert property (alarm.valid && alarm.number < 9'h100 |->
        alarm.severity == ssia_pkg::SEV_ERROR) else $error("error alarm severity wrong");
    a_sev_maint: assert property (alarm.valid && alarm.number >= ssia_pkg::MAINT_FIRST |->
        alarm.severity == ssia_pkg::SEV_MAINT) else $error("maintenance severity wrong");
endmodule
bind ssia_status_image_alarms ssia_status_image_alarms_asserts #(.PATHS(PATHS)) chk (.clk(clk),
    .sys_rst(sys_rst), .read(read), .write(write), .waitrequest(waitrequest),
    .pathNonsafeIn(pathNonsafeIn), .pathRearmIn(pathRearmIn), .contourLostIn(contourLostIn),
    .angleBlindIn(angleBlindIn), .safeImage(safeImage), .plainImage(plainImage), .alarm(alarm),
    .safeOutputsOff(safeOutputsOff));

// ===== ssia_ctrl_model.sv
`timescale 1ns/10ps
module ssia_ctrl_model (
    // Clock
    input wire logic clk,
    // Alarm from device
    input wire ssia_pkg::ssia_alarm_type alarm,
    // New alarm seen
    output logic alarmSeen
);
    ssia_pkg::ssia_alarm_type lastAlarm_q;
    always_ff @(posedge clk) begin
        lastAlarm_q <= alarm;
    end
    // Controller logs an alarm once, on a new number or a fresh valid
    assign alarmSeen = alarm.valid && (!lastAlarm_q.valid || alarm.number != lastAlarm_q.number);
endmodule

// ===== ssia_status_image_alarms_tb.sv
`timescale 1ns/10ps
module ssia_status_image_alarms_tb;
    `define CHK(g, w) begin nChecks++; if ((g) !== (w)) begin errTotal++; \
        $display("Error at %0t: got %h want %h", $time, g, w); end end
    logic clk = 0, sysRst = 1, read = 0, write = 0, seen, outOff;
    logic [7:0] address = 8'h00, pSafe = 8'h00, pNon = 8'h00, pRearm = 8'h00, mask, cs;
    logic [31:0] writedata = 32'h0, readdata;
    logic waitrequest;
    logic [5:0] flt = 6'h00;
    logic [1:0] rxLen = 2'h0;
    logic [47:0] safeImage, plainImage;
    ssia_pkg::ssia_alarm_type alarm;
    logic [31:0] rdq [$];
    logic [10:0] aq [$];
    logic [31:0] rdExp;
    logic [10:0] alExp;
    logic [8:0] tbl [19] = '{9'h104, 9'h105, 9'h047, 9'h04d, 9'h04b, 9'h04e, 9'h100, 9'h101, 9'h048,
        9'h106, 9'h040, 9'h043, 9'h044, 9'h045, 9'h046, 9'h04c, 9'h102, 9'h103, 9'h107};
    int errTotal = 0, nChecks = 0;
    always #5 clk = ~clk;
    ssia_status_image_alarms #(.DEVICE_SIL(2'h1)) dut (.clk(clk), .sys_rst(sysRst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(waitrequest), .pathSafeIn(pSafe), .pathNonsafeIn(pNon), .pathRearmIn(pRearm),
        .contourLostIn(flt[0]), .angleBlindIn(flt[1]), .crc1BadIn(flt[2]), .crc2BadIn(flt[3]),
        .iparCrcBadIn(flt[4]), .watchdogExpiredIn(flt[5]), .rxCrcLen4In(rxLen), .safeImage(safeImage),
        .plainImage(plainImage), .alarm(alarm), .safeOutputsOff(outOff));
    ssia_ctrl_model ctrl (.clk(clk), .alarm(alarm), .alarmSeen(seen));
    ////////////////////////////////////////////////////////////////
    // Watcher: pops the oldest note whenever a result shows
    always @(posedge clk) begin
        if (read && !waitrequest) begin
            rdExp = rdq.pop_front();
            `CHK(readdata, rdExp)
        end
        if (seen === 1'b1 && aq.size() > 0) begin
            alExp = aq.pop_front();
            `CHK({alarm.number, alarm.severity}, alExp)
        end
    end
    task automatic summarize;
        $display("checks %0d errors %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Leading edge keeps two requests from landing in one time step
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge clk); while (waitrequest !== 1'b0 && ++n < 50);
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) errTotal++;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        rdq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic fp(input logic [15:0] dst, input logic [15:0] wd, input logic [6:0] lo);
        bus(1'b1, ssia_pkg::ADDR_SAFE_OUT, {dst, 16'h0002});
        bus(1'b1, ssia_pkg::ADDR_FPARAM, {9'h0, wd, lo});
    endtask
    task automatic setFault(input int k, input logic on);
        if (k < 6)
            flt[k] <= on;
        else if (k < 10)
            bus(1'b1, ssia_pkg::ADDR_FAULT_IN, on ? 32'h1 << (k - 6) : 32'h0);
        else if (k == 13)
            rxLen <= {1'b0, on};
        else if (k == 18) begin
            // Leave run mode before expiry so alarm 78 never fires here
            if (on) bus(1'b1, ssia_pkg::ADDR_MODE_CTRL, 32'h0);
            flt[5] <= on;
            if (!on) bus(1'b1, ssia_pkg::ADDR_MODE_CTRL, 32'h1);
        end
        else if (k > 15)
            bus(1'b1, ssia_pkg::ADDR_MODE_CTRL, on ? (k == 16 ? 32'h5 : 32'h9) : 32'h1);
        else
            fp((k == 10 && on) ? 16'h0002 : 16'h0001, (k == 11 && on) ? 16'h0000 : 16'h0064,
                (on && k == 12) ? 7'h40 : (on && k == 14) ? 7'h24 : (on && k == 15) ? 7'h22 : 7'h20);
    endtask
    task automatic alarmCase(input int k);
        int i, n;
        for (i = 0; i < ssia_pkg::NUM_ALARMS; i++)
            if (ssia_pkg::ALARM_NUMBER[i] == tbl[k]) break;
        aq.push_back({tbl[k], tbl[k] < 9'h100 ? 2'h1 : 2'h2});
        setFault(k, 1'b1);
        n = 0;
        // Wait for the watcher to take the note; the alarm may already have shown
        do @(posedge clk); while (aq.size() != 0 && ++n < 40);
        if (n >= 40) errTotal++;
        if (k < 2 || k == 17) `CHK(outOff, 1'b1)
        setFault(k, 1'b0);
        bus(1'b1, ssia_pkg::ADDR_ALARM_ACK, 32'h1 << i);
        repeat (3) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(22));
        repeat (12) @(posedge clk);
        sysRst <= 1'b0;
        fp(16'h0001, 16'h0064, 7'h20);
        bus(1'b1, ssia_pkg::ADDR_MODE_CTRL, 32'h1);
        bus(1'b1, ssia_pkg::ADDR_ALARM_ACK, 32'hfffff);
        repeat (3) @(posedge clk);
        rdx(ssia_pkg::ADDR_ALARM_ACK, 32'h0);
        rdx(8'hfc, ssia_pkg::UNMAPPED_READ);
        $display("test setup done");
        for (int j = 0; j < 8; j++) begin
            pSafe <= $urandom;
            pNon <= $urandom;
            pRearm <= $urandom;
            mask = $urandom;
            cs = $urandom;
            bus(1'b1, ssia_pkg::ADDR_PATH_CTRL, {24'h0, mask});
            bus(1'b1, ssia_pkg::ADDR_MODE_CTRL, {16'h0, cs, 8'h01});
            repeat (2) @(posedge clk);
            rdx(ssia_pkg::ADDR_SAFE_IMG, {pRearm, pNon, pSafe & mask, 8'h01});
            `CHK(plainImage[39:16], {cs, pRearm, pNon})
        end
        bus(1'b1, ssia_pkg::ADDR_MODE_CTRL, 32'h1);
        $display("test images done");
        for (int k = 0; k < 19; k++)
            alarmCase(k);
        $display("test alarms done");
        summarize();
    end
    initial begin
        #200000;
        errTotal++;
        summarize();
    end
endmodule
